// ==== shared/cisf_pkg.sv ====
// Constants and types shared by the serial frame block and its FIFO.
// Assumes a single 50 MHz reference clock and no software register bus.
package cisf_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int         FRAME_BITS = 16;
  localparam int         CNT_W      = 5;
  localparam logic [4:0] CNT_LAST   = 5'h0f;
  localparam int         SYNC_IN_W  = 11;

  // Field positions of a received frame used by the local decoder.
  localparam int         CMD_MSB    = 15;
  localparam int         CMD_LSB    = 12;
  localparam int         ROLE_MSB   = 9;
  localparam int         ROLE_LSB   = 8;
  localparam int         MASK_MSB   = 7;
  localparam logic [3:0] CMD_ROLE   = 4'h1;
  localparam logic [3:0] CMD_GPIO   = 4'h2;
  localparam logic [3:0] CMD_BUSY   = 4'h3;

  // ****************************************
  // Pins
  // ****************************************
  localparam int NUM_PINS   = 8;
  localparam int BUSY_PIN   = 7;
  localparam int FIFO_DEPTH = 16;

  // Sync vector order: {frame select, serial clock, serial data, pins}.
  localparam int         IDX_SEL  = 10;
  localparam int         IDX_SCLK = 9;
  localparam int         IDX_SDI  = 8;
  localparam logic [10:0] SYNC_RST = 11'h400;

  typedef enum logic [1:0] {
    CISF_ROLE_DIG_IN,
    CISF_ROLE_DIG_OUT,
    CISF_ROLE_ANA_IN,
    CISF_ROLE_ANA_OUT
  } cisf_role_t;

  localparam cisf_role_t ROLE_RST = CISF_ROLE_DIG_IN;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_HOLD,
    ST_DONE
  } cisf_state_t;

endpackage

// ==== shared/cisf_stream_if.sv ====
// Valid/ready word stream between the frame logic and its FIFO.
// Assumes source and sink share one clock.
`timescale 1ns/10ps
`default_nettype none
interface cisf_stream_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== src/cisf_fifo.sv ====
// Synchronous FIFO with a registered read port.
// Assumes writer and reader run on the same clock and reset.
`timescale 1ns/10ps
`default_nettype none
module cisf_fifo
  import cisf_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic  clk,
  input wire logic  rst_n,
  cisf_stream_if.snk wr,
  cisf_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    cnt_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             pop;

  // The output stage refills as soon as it is empty or being drained.
  assign wr.ready = (cnt_ff != FULL_CNT);
  assign push     = wr.valid & wr.ready;
  assign pop      = (cnt_ff != '0) & (~out_valid_ff | rd.ready);
  assign rd.valid = out_valid_ff;
  assign rd.data  = out_data_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem_ff[rd_ptr_ff];
    end else if (rd.ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule // cisf_fifo
`default_nettype wire

// ==== src/cisf_serial_frame.sv ====
// Serial frame slave and pin control of an eight-pin configurable I/O device.
// Assumes the host clock, frame select and data arrive asynchronously to ref_clk
// and are oversampled; conversion busy, output word and drain side share ref_clk.
`timescale 1ns/10ps
`default_nettype none

module cisf_serial_frame
  import cisf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  frame_sel_n,
  input  wire logic                  serial_clk,
  input  wire logic                  serial_in,
  output var  logic                  serial_out,
  input  wire logic [NUM_PINS-1:0]   config_pin_in,
  output var  logic [NUM_PINS-1:0]   config_pin_out,
  output var  logic [NUM_PINS-1:0]   config_pin_oe,
  output var  logic [2*NUM_PINS-1:0] pin_role,
  output var  logic [NUM_PINS-1:0]   pin_din,
  input  wire logic                  conv_busy,
  input  wire logic [FRAME_BITS-1:0] tx_word,
  input  wire logic                  tx_load,
  output var  logic [FRAME_BITS-1:0] rx_data,
  output var  logic                  rx_valid,
  input  wire logic                  rx_ready,
  output var  logic                  overrun
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_IN_W-1:0] s1_ff;
  logic [SYNC_IN_W-1:0] s2_ff;
  logic [SYNC_IN_W-1:0] s3_ff;
  logic [SYNC_IN_W-1:0] flt_ff;
  logic [SYNC_IN_W-1:0] flt_d_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
      s3_ff <= SYNC_RST;
    end else begin
      s1_ff <= {frame_sel_n, serial_clk, serial_in, config_pin_in};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A level is accepted only once two late stages agree, which rejects a
  // single metastable sample at the cost of one more cycle of delay.
  for (genvar i = 0; i < SYNC_IN_W; i++) begin : g_flt
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        flt_ff[i]   <= SYNC_RST[i];
        flt_d_ff[i] <= SYNC_RST[i];
      end else begin
        if (s2_ff[i] == s3_ff[i]) begin
          flt_ff[i] <= s3_ff[i];
        end
        flt_d_ff[i] <= flt_ff[i];
      end
    end
  end

  logic sel_low;
  logic sel_fall;
  logic sclk_fall;
  logic sclk_rise;

  assign sel_low   = ~flt_ff[IDX_SEL];
  assign sel_fall  = flt_d_ff[IDX_SEL] & ~flt_ff[IDX_SEL];
  assign sclk_fall = flt_d_ff[IDX_SCLK] & ~flt_ff[IDX_SCLK];
  assign sclk_rise = ~flt_d_ff[IDX_SCLK] & flt_ff[IDX_SCLK];

  // ****************************************
  // Receive frame
  // ****************************************
  cisf_stream_if #(.WIDTH(FRAME_BITS)) wr_if ();
  cisf_stream_if #(.WIDTH(FRAME_BITS)) rd_if ();

  cisf_state_t           state_ff;
  logic [CNT_W-1:0]      bit_cnt_ff;
  logic [FRAME_BITS-1:0] rx_sh_ff;
  logic                  overrun_ff;
  logic                  push;

  assign wr_if.valid = (state_ff == ST_HOLD);
  assign wr_if.data  = rx_sh_ff;
  assign push        = wr_if.valid & wr_if.ready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= '0;
      rx_sh_ff   <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (sel_fall) begin
            state_ff   <= ST_SHIFT;
            bit_cnt_ff <= '0;
          end
        end
        ST_SHIFT: begin
          if (!sel_low) begin
            state_ff <= ST_IDLE;
          end else if (sclk_fall) begin
            rx_sh_ff   <= {rx_sh_ff[FRAME_BITS-2:0], flt_ff[IDX_SDI]};
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            if (bit_cnt_ff == CNT_LAST) begin
              state_ff <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (push) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Clocks beyond the sixteenth are ignored until deselect.
          if (!sel_low) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // A frame that starts while the last one still waits for FIFO room is lost.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else begin
      overrun_ff <= sel_fall & (state_ff == ST_HOLD);
    end
  end

  cisf_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .wr    (wr_if),
    .rd    (rd_if)
  );

  assign rd_if.ready = rx_ready;
  assign rx_data     = rd_if.data;
  assign rx_valid    = rd_if.valid;
  assign overrun     = overrun_ff;

  // ****************************************
  // Transmit stream
  // ****************************************
  logic [FRAME_BITS-1:0] tx_pend_ff;
  logic [FRAME_BITS-1:0] tx_sh_ff;
  logic                  fall_seen_ff;
  logic                  serial_out_ff;

  // Results, readback and temperature all arrive through this one word.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pend_ff <= '0;
    end else if (tx_load) begin
      tx_pend_ff <= tx_word;
    end
  end

  // The MSB follows frame select with only the synchroniser latency.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_ff      <= '0;
      fall_seen_ff  <= 1'b0;
      serial_out_ff <= 1'b0;
    end else if (sel_fall) begin
      tx_sh_ff      <= tx_pend_ff;
      serial_out_ff <= tx_pend_ff[FRAME_BITS-1];
      fall_seen_ff  <= 1'b0;
    end else if (sel_low && sclk_fall) begin
      fall_seen_ff <= 1'b1;
    end else if (sel_low && sclk_rise && fall_seen_ff) begin
      tx_sh_ff      <= {tx_sh_ff[FRAME_BITS-2:0], 1'b0};
      serial_out_ff <= tx_sh_ff[FRAME_BITS-2];
      fall_seen_ff  <= 1'b0;
    end
  end

  assign serial_out = serial_out_ff;

  // ****************************************
  // Pin configuration
  // ****************************************
  logic [NUM_PINS-1:0] gpio_ff;
  logic                busy_en_ff;
  logic [3:0]          cmd;

  assign cmd        = rx_sh_ff[CMD_MSB:CMD_LSB];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_ff    <= '0;
      busy_en_ff <= 1'b0;
    end else if (push) begin
      if (cmd == CMD_GPIO) begin
        gpio_ff <= rx_sh_ff[MASK_MSB:0];
      end
      if (cmd == CMD_BUSY) begin
        busy_en_ff <= rx_sh_ff[0];
      end
    end
  end

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    cisf_role_t role_ff;
    logic       out_ff;
    logic       oe_ff;
    logic       din_ff;
    logic       busy_sel;

    assign busy_sel = (p == BUSY_PIN) && busy_en_ff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        role_ff <= ROLE_RST;
      end else if (push && cmd == CMD_ROLE && rx_sh_ff[p]) begin
        role_ff <= cisf_role_t'(rx_sh_ff[ROLE_MSB:ROLE_LSB]);
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        out_ff <= 1'b0;
        oe_ff  <= 1'b0;
        din_ff <= 1'b0;
      end else begin
        oe_ff  <= busy_sel || (role_ff == CISF_ROLE_DIG_OUT);
        out_ff <= busy_sel ? conv_busy : gpio_ff[p];
        din_ff <= (role_ff == CISF_ROLE_DIG_IN) & flt_ff[p];
      end
    end

    assign config_pin_out[p]     = out_ff;
    assign config_pin_oe[p]      = oe_ff;
    assign pin_din[p]            = din_ff;
    assign pin_role[2*p +: 2]    = role_ff;
  end

endmodule // cisf_serial_frame
`default_nettype wire

// ==== tb/cisf_frame_monitor.sv ====
// Checker for the serial frame block, bound to its top module.
// Assumes host pins move away from ref_clk edges and tx_word holds through a frame.
`timescale 1ns/10ps
`default_nettype none
module cisf_frame_monitor
  import cisf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        frame_sel_n,
  input wire logic        serial_clk,
  input wire logic        serial_in,
  input wire logic        serial_out,
  input wire logic [7:0]  config_pin_in,
  input wire logic [7:0]  config_pin_out,
  input wire logic [7:0]  config_pin_oe,
  input wire logic [15:0] pin_role,
  input wire logic [7:0]  pin_din,
  input wire logic        conv_busy,
  input wire logic [15:0] tx_word,
  input wire logic        tx_load,
  input wire logic [15:0] rx_data,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic        overrun
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic        sclk_ff;
  logic        sel_ff;
  logic [3:0]  since_ff;
  logic [15:0] role_ff;
  logic [15:0] role2_ff;
  logic [2:0]  busy_ff;
  logic [7:0]  dout;
  logic [7:0]  din_ok;
  logic        steady;
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      dout[p]   = pin_role[2*p+:2] == 2'h1;
      din_ok[p] = pin_role[2*p+:2] == 2'h0;
    end
  end
  // Pin outputs lag a role change, so they are judged only once the roles have settled.
  assign steady = pin_role == role_ff && role_ff == role2_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_ff  <= 1'b1;
      sel_ff   <= 1'b1;
      since_ff <= 4'hf;
    end else begin
      sclk_ff <= serial_clk;
      sel_ff  <= frame_sel_n;
      if ((serial_clk && !sclk_ff) || (sel_ff && !frame_sel_n)) since_ff <= 4'h0;
      else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      role_ff  <= 16'h0000;
      role2_ff <= 16'h0000;
      busy_ff  <= 3'h0;
    end else begin
      role_ff  <= pin_role;
      role2_ff <= role_ff;
      busy_ff  <= {busy_ff[1:0], conv_busy};
    end
  end
  a_msb_on_select: assert property (
    $fell(frame_sel_n) |-> ##[4:7] serial_out == tx_word[15])
    else $error("first output bit is not the pending msb");
  a_shift_on_rise: assert property (
    $changed(serial_out) |-> since_ff inside {[4'h3:4'h7]})
    else $error("output bit moved without a launching host edge");
  a_oe_follows_role: assert property (
    steady |-> config_pin_oe[6:0] == dout[6:0])
    else $error("pin drive does not match digital output role");
  a_din_gated: assert property (
    steady |-> (pin_din & ~din_ok) == 8'h00)
    else $error("pin input seen on a pin that is not a digital input");
  a_busy_on_pin: assert property (
    config_pin_oe[7] && !dout[7] && busy_ff == {3{conv_busy}} |-> config_pin_out[7] == conv_busy)
    else $error("pin seven does not follow conversion busy");
  a_rx_word_held: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received word dropped before it was taken");
  a_overrun_pulse: assert property (
    overrun |=> !overrun)
    else $error("overrun longer than one cycle");
  a_reset_default: assert property (
    $rose(rst_n) |-> pin_role == 16'h0000 && config_pin_oe == 8'h00 && !rx_valid)
    else $error("configuration not at default after reset");
endmodule // cisf_frame_monitor
bind cisf_serial_frame cisf_frame_monitor #(.DEPTH(DEPTH)) mon_u (
  .ref_clk, .rst_n, .frame_sel_n, .serial_clk, .serial_in, .serial_out, .config_pin_in,
  .config_pin_out, .config_pin_oe, .pin_role, .pin_din, .conv_busy, .tx_word, .tx_load,
  .rx_data, .rx_valid, .rx_ready, .overrun
);
`default_nettype wire

// ==== tb/cisf_host_model.sv ====
// Host serial controller: frames words onto the link at a 160 ns clock period.
// Assumes the caller starts each transfer with frame select idle high.
`timescale 1ns/10ps
`default_nettype none
module cisf_host_model (
  input  wire logic ref_clk,
  output var  logic frame_sel_n,
  output var  logic serial_clk,
  output var  logic serial_in,
  input  wire logic serial_out
);
  initial begin
    frame_sel_n = 1'b1;
    serial_clk  = 1'b1;
    serial_in   = 1'b0;
  end
  // The clock idles high and stands still between frames; a short count aborts the frame.
  task automatic xfer(input logic [15:0] d, input int nb, output logic [15:0] q);
    q = 16'h0000;
    @(posedge ref_clk);
    #1;
    frame_sel_n = 1'b0;
    #160;
    for (int i = 15; i > 15 - nb; i--) begin
      serial_in = d[i];
      #80 serial_clk = 1'b0;
      // Sampled late because the output trails the rising edge by several ref_clk cycles.
      #70 q[i] = serial_out;
      #10 serial_clk = 1'b1;
    end
    #80 frame_sel_n = 1'b1;
    #80 serial_in = ~serial_in;
    #100;
  endtask
endmodule // cisf_host_model
`default_nettype wire

// ==== tb/config_io_serial_frame_tb_top.sv ====
// Self-checking bench of the serial frame block with a host model on the link.
// Assumes the checker is bound to the block and this bench is the drain side.
`timescale 1ns/10ps
`default_nettype none
module config_io_serial_frame_tb_top;
  import cisf_pkg::*;
  logic        ref_clk, rst_n, frame_sel_n, serial_clk, serial_in, serial_out;
  logic        conv_busy, tx_load, rx_valid, rx_ready, overrun, ovr_seen;
  logic [7:0]  config_pin_in, config_pin_out, config_pin_oe, pin_din;
  logic [15:0] pin_role, tx_word, rx_data, got_q;
  int          n_fail, comparisons, cyc;
  cisf_serial_frame #(.DEPTH(FIFO_DEPTH)) dut_u (
    .ref_clk, .rst_n, .frame_sel_n, .serial_clk, .serial_in, .serial_out, .config_pin_in,
    .config_pin_out, .config_pin_oe, .pin_role, .pin_din, .conv_busy, .tx_word, .tx_load,
    .rx_data, .rx_valid, .rx_ready, .overrun
  );
  cisf_host_model host_u (.ref_clk, .frame_sel_n, .serial_clk, .serial_in, .serial_out);
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (overrun === 1'b1) ovr_seen <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pop();
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask
  task automatic get_rx(input logic [15:0] exp);
    for (int k = 0; k < 400 && rx_valid !== 1'b1; k++) tick(1);
    chk("rx_data", exp, rx_data);
    pop();
  endtask
  task automatic xf(input logic [15:0] d, input logic [15:0] tx, input int nb);
    tx_word = tx;
    tx_load = 1'b1;
    tick(1);
    tx_load = 1'b0;
    host_u.xfer(d, nb, got_q);
  endtask
  task automatic t_reset();
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(5);
    chk("pin_role", 16'h0000, pin_role);
    chk("oe_valid_out", 16'h0000, {config_pin_oe, 6'h00, rx_valid, serial_out});
  endtask
  task automatic t_loop();
    logic [15:0] tab [2] = '{16'ha5c3, 16'h5a3c};
    for (int i = 0; i < 2; i++) begin
      xf({4'h0, tab[i][11:0]}, tab[i], 16);
      chk("host_rx", tab[i], got_q);
      get_rx({4'h0, tab[i][11:0]});
    end
  endtask
  task automatic t_roles();
    for (int r = 0; r < 4; r++) begin
      xf({4'h1, 2'b00, r[1:0], 8'h01 << r}, 16'h0000, 16);
      get_rx({4'h1, 2'b00, r[1:0], 8'h01 << r});
    end
    xf(16'h20ff, 16'h0000, 16);
    get_rx(16'h20ff);
    config_pin_in = 8'hff;
    tick(10);
    chk("pin_role", 16'h00e4, pin_role);
    chk("pin_oe", 16'h0002, {8'h00, config_pin_oe});
    chk("pin_out", 16'h0002, {8'h00, config_pin_out & config_pin_oe});
    chk("pin_din", 16'h00f1, {8'h00, pin_din});
  endtask
  task automatic t_busy();
    xf(16'h3001, 16'h0000, 16);
    get_rx(16'h3001);
    conv_busy = 1'b1;
    tick(6);
    chk("busy_pin", 16'h0003, {14'h0, config_pin_oe[7], config_pin_out[7]});
    conv_busy = 1'b0;
    tick(6);
    chk("busy_pin", 16'h0002, {14'h0, config_pin_oe[7], config_pin_out[7]});
  endtask
  task automatic t_abort();
    xf(16'h0f0f, 16'h0000, 8);
    tick(20);
    chk("rx_valid", 16'h0000, {15'h0, rx_valid});
    xf(16'h0bee, 16'h0000, 16);
    get_rx(16'h0bee);
  endtask
  // The drain side stalls while frames pile up. The FIFO and its output stage hold
  // DEPTH + 1 words and the frame logic holds one more, so only a further frame is lost.
  task automatic t_fifo();
    ovr_seen = 1'b0;
    for (int i = 0; i < FIFO_DEPTH + 3; i++) xf(16'(i), 16'h0000, 16);
    chk("overrun", 16'h0001, {15'h0, ovr_seen});
    for (int i = 0; i < FIFO_DEPTH + 2; i++) get_rx(16'(i));
    tick(40);
    chk("rx_valid", 16'h0000, {15'h0, rx_valid});
  endtask
  initial begin
    rst_n = 1'b0;
    tx_word = 16'h0000;
    tx_load = 1'b0;
    rx_ready = 1'b0;
    conv_busy = 1'b0;
    config_pin_in = 8'h00;
    ovr_seen = 1'b0;
    tick(10);
    rst_n = 1'b1;
    tick(5);
    t_reset();
    t_loop();
    t_roles();
    t_reset();
    t_busy();
    t_abort();
    t_fifo();
    stop_test();
  end
endmodule // config_io_serial_frame_tb_top
`default_nettype wire
